// [logic/fsd_delay_timer.sv]
// Down counter giving a done pulse after a loaded delay
`timescale 1ns/100ps
module fsd_delay_timer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] remain;
    logic running;

    // ==========================================================
    // Countdown
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            remain <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remain <= count;
                running <= 1'b1;
            end else if (running) begin
                if (remain <= W'(1)) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    remain <= remain - W'(1);
                end
            end
        end
    end
endmodule // fsd_delay_timer

// [logic/fsd_status_sleep.sv]
// Status bytes and deep power-down control of the serial flash
// What this block does
// R1 - Bit 7 of both status bytes reads 0 while busy, 1 when ready.
// R2 - Byte 2 bit 5 reads 1 after an erase or program error.
// R3 - Byte 2 bits 6 and 4 always read 0.
// R4 - Byte 2 bit 3 reads 1 while sector lockdown is still enabled.
// R5 - Byte 2 bits 2 and 1 flag program suspended on buffer 2 or 1.
// R6 - Byte 2 bit 0 reads 1 while an erase is suspended.
// R7 - Host polls fresh status bytes until ready/busy changes.
// R8 - Compare flag holds last page-to-buffer compare; 1 on any mismatch.
// R9 - Byte 1 carries a fixed four-bit capacity code.
// R10 - Protect flag is 1 if software or hardware protection is enabled.
// R11 - Page-size flag shows 512 or 528 byte configuration.
// R12 - Error flag set on any bad byte, updated after every operation.
// R13 - Error flag stays clear when an operation is aborted.
// R14 - Buffer-modifying commands are blocked while that buffer is suspended.
// R15 - Once lockdown flag is 0, lockdown requests are refused.
// R16 - Standby when deselected and idle; standby after power-up.
// R17 - In deep sleep only the resume opcode is honoured.
// R18 - Opcode B9h then deselect enters deep sleep after entry delay.
// R19 - Sleep entry aborts on short opcode or non-byte deselect.
// R20 - Sleep entry is ignored while a self-timed operation runs.
// R21 - Opcode ABh then deselect returns to standby after wake delay.
// R22 - Incomplete or misaligned resume keeps the device asleep.
// R23 - Opcode D7h streams byte 1 then byte 2, repeating while selected.
// R24 - Compare flag is byte 1 bit 6, updated when compare completes.
// R25 - Entry and wake delays are cycle-count parameters.
`timescale 1ns/100ps
module fsd_status_sleep
    import fsd_pkg::*;
#(
    parameter int ENTRY_CYCLES = ENTRY_CYCLES_DEF,
    parameter int WAKE_CYCLES = WAKE_CYCLES_DEF,
    parameter logic [3:0] DENSITY_CODE = DENSITY_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sck,
    input wire logic cs_b,
    input wire logic si,
    output logic so,
    output logic so_oe_b,
    input wire logic op_busy,
    input wire logic compare_done,
    input wire logic compare_mismatch,
    input wire logic op_done,
    input wire logic op_error,
    input wire logic op_aborted,
    input wire logic protect_sw,
    input wire logic protect_pin_b,
    input wire logic page_size_528,
    input wire logic lockdown_disable,
    input wire logic lockdown_req,
    input wire logic suspend_buf1,
    input wire logic suspend_buf2,
    input wire logic erase_suspend,
    output logic [7:0] status_byte_first,
    output logic [7:0] status_byte_second,
    output logic standby_mode,
    output logic deep_sleep,
    output logic cmd_open,
    output logic lockdown_grant,
    output logic buf1_write_block,
    output logic buf2_write_block
);

    // ==========================================================
    // Elaboration checks
    // R25 - delay parameter limits
    if (ENTRY_CYCLES < 1 || ENTRY_CYCLES >= (1 << TIMER_W)) begin : g_chk_e
        $error("ENTRY_CYCLES out of range");
    end
    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << TIMER_W)) begin : g_chk_w
        $error("WAKE_CYCLES out of range");
    end

    // ==========================================================
    // Declarations
    fsd_state_e state;
    fsd_state_e next_state;
    logic cmp_flag;
    logic epe_flag;
    logic sle_flag;
    logic prot_pin_s;
    logic cs_s;
    logic cs_prev;
    logic tgl_s;
    logic tgl_seen;
    logic frame_end;
    logic frame_ok;
    logic timer_start;
    logic [TIMER_W-1:0] timer_count;
    logic timer_done;
    logic [STATUS_BITS-1:0] status_word;
    // Link side
    logic frame_rst;
    logic in_frame;
    logic [2:0] bit_cnt;
    logic got_byte;
    logic [6:0] shift_in;
    logic [7:0] opcode;
    logic frame_tgl;
    logic open_l;
    logic [STATUS_BITS-1:0] status_l;
    logic status_on;
    logic [3:0] out_idx;
    logic start_out;

    // ==========================================================
    // Clock domain crossings
    fsd_sync2 #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_prot (
        .clk(clk),
        .rst_b(rst_b),
        .d(protect_pin_b),
        .q(prot_pin_s)
    );

    fsd_sync2 #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_cs (
        .clk(clk),
        .rst_b(rst_b),
        .d(cs_b),
        .q(cs_s)
    );

    fsd_sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_tgl (
        .clk(clk),
        .rst_b(rst_b),
        .d(frame_tgl),
        .q(tgl_s)
    );

    fsd_sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_open (
        .clk(sck),
        .rst_b(rst_b),
        .d(cmd_open),
        .q(open_l)
    );

    fsd_sync2 #(.WIDTH(STATUS_BITS), .RESET_VAL('0)) u_sync_stat (
        .clk(sck),
        .rst_b(rst_b),
        .d(status_word),
        .q(status_l)
    );

    // ==========================================================
    // Link: frame tracking
    assign frame_rst = cs_b | ~rst_b;

    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // R19 - bit count per frame
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt <= BITCNT_ZERO;
            got_byte <= 1'b0;
            shift_in <= '0;
            opcode <= '0;
            frame_tgl <= 1'b0;
        end else if (!in_frame) begin
            bit_cnt <= BITCNT_ONE;
            got_byte <= 1'b0;
            shift_in <= {6'h00, si};
            frame_tgl <= ~frame_tgl;
        end else begin
            bit_cnt <= bit_cnt + BITCNT_ONE;
            shift_in <= {shift_in[5:0], si};
            // R18 - trailing bits ignored
            if (bit_cnt == BITCNT_LAST && !got_byte) begin
                got_byte <= 1'b1;
                opcode <= {shift_in, si};
            end
        end
    end

    // ==========================================================
    // Link: status output
    // R17 - status read only when commands open
    assign start_out = got_byte && (opcode == OP_STATUS) && open_l;

    // R23 - stream byte 1 then byte 2
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            status_on <= 1'b0;
            out_idx <= OUTIDX_ZERO;
            so <= 1'b0;
            so_oe_b <= 1'b1;
        end else if (status_on || start_out) begin
            status_on <= 1'b1;
            so_oe_b <= 1'b0;
            // R7 - word refreshed on every pass
            so <= status_l[OUTIDX_TOP - out_idx];
            out_idx <= out_idx + 4'h1;
        end
    end

    // ==========================================================
    // Frame end decode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_prev <= 1'b1;
            tgl_seen <= 1'b0;
        end else begin
            cs_prev <= cs_s;
            if (frame_end) begin
                tgl_seen <= tgl_s;
            end
        end
    end

    assign frame_end = cs_s && !cs_prev;
    // R19 - full opcode and byte boundary
    assign frame_ok = frame_end && (tgl_s != tgl_seen) && got_byte &&
        (bit_cnt == BITCNT_ZERO);

    // ==========================================================
    // Power state machine
    always_comb begin
        next_state = state;
        timer_start = 1'b0;
        timer_count = TIMER_W'(ENTRY_CYCLES);
        case (state)
            FSD_STANDBY: begin
                // R18 - enter on sleep opcode
                // R20 - ignored while busy
                if (frame_ok && opcode == OP_SLEEP && !op_busy) begin
                    next_state = FSD_ENTER;
                    timer_start = 1'b1;
                end
            end
            FSD_ENTER: begin
                if (timer_done) begin
                    next_state = FSD_SLEEP;
                end
            end
            FSD_SLEEP: begin
                // R21 - resume opcode wakes
                // R22 - bad resume stays asleep
                if (frame_ok && opcode == OP_WAKE) begin
                    next_state = FSD_WAKE;
                    timer_start = 1'b1;
                    timer_count = TIMER_W'(WAKE_CYCLES);
                end
            end
            FSD_WAKE: begin
                if (timer_done) begin
                    next_state = FSD_STANDBY;
                end
            end
            default: begin
                next_state = FSD_STANDBY;
            end
        endcase
    end

    // R16 - standby after power-up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= FSD_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    // R25 - counted delays
    fsd_delay_timer #(.W(TIMER_W)) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(timer_start),
        .count(timer_count),
        .done(timer_done)
    );

    // ==========================================================
    // Mode outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            standby_mode <= 1'b1;
            deep_sleep <= 1'b0;
            cmd_open <= 1'b1;
        end else begin
            // R16 - idle and deselected
            standby_mode <= (next_state == FSD_STANDBY) && cs_s &&
                !op_busy;
            deep_sleep <= (next_state == FSD_SLEEP);
            // R17 - commands closed outside standby
            cmd_open <= (next_state == FSD_STANDBY);
        end
    end

    // ==========================================================
    // Status flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_flag <= 1'b0;
        end else if (compare_done) begin
            // R8 - last compare result
            // R24 - updated on completion
            cmp_flag <= compare_mismatch;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            epe_flag <= 1'b0;
        end else if (op_done) begin
            // R12 - updated every operation
            // R13 - aborts never set it
            epe_flag <= op_error && !op_aborted;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sle_flag <= SLE_RESET;
        end else if (lockdown_disable) begin
            // R4 - lockdown disabled until next reset
            sle_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Status assembly
    always_comb begin
        status_word = '0;
        // R1 - ready/busy in both bytes
        status_word[BYTE_BITS + ST_RDY] = !op_busy;
        status_word[BYTE_BITS + B1_CMP] = cmp_flag;
        // R9 - fixed capacity code
        status_word[BYTE_BITS + B1_DEN_MSB:BYTE_BITS + B1_DEN_LSB] =
            DENSITY_CODE;
        // R10 - either protection method
        status_word[BYTE_BITS + B1_PROT] = protect_sw || !prot_pin_s;
        // R11 - page size flag
        status_word[BYTE_BITS + B1_PSZ] = page_size_528;
        status_word[ST_RDY] = !op_busy;
        // R3 - reserved bits
        status_word[B2_RES_HI] = RESERVED_VAL;
        status_word[B2_RES_LO] = RESERVED_VAL;
        // R2 - error flag
        status_word[B2_EPE] = epe_flag;
        status_word[B2_SLE] = sle_flag;
        // R5 - program suspend per buffer
        status_word[B2_PS2] = suspend_buf2;
        status_word[B2_PS1] = suspend_buf1;
        // R6 - erase suspended
        status_word[B2_ES] = erase_suspend;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_byte_first <= '0;
            status_byte_second <= '0;
        end else begin
            status_byte_first <= status_word[STATUS_BITS-1:BYTE_BITS];
            status_byte_second <= status_word[BYTE_BITS-1:0];
        end
    end

    // ==========================================================
    // Command gating
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            buf1_write_block <= 1'b0;
            buf2_write_block <= 1'b0;
            lockdown_grant <= 1'b0;
        end else begin
            // R14 - suspended buffer protected
            buf1_write_block <= suspend_buf1;
            buf2_write_block <= suspend_buf2;
            // R15 - lockdown refused once disabled
            lockdown_grant <= lockdown_req && sle_flag &&
                !lockdown_disable && (state == FSD_STANDBY);
        end
    end

endmodule // fsd_status_sleep

// [logic/fsd_sync2.sv]
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module fsd_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // ==========================================================
    // Capture stages
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // fsd_sync2

// [pkg/fsd_pkg.sv]
// Constants and types shared by the status and deep-sleep block
package fsd_pkg;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE = 8'hab;
    localparam logic [7:0] OP_STATUS = 8'hd7;

    // ==========================================================
    // Status field positions
    localparam int STATUS_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int ST_RDY = 7;
    localparam int B1_CMP = 6;
    localparam int B1_DEN_LSB = 2;
    localparam int B1_DEN_MSB = 5;
    localparam int B1_PROT = 1;
    localparam int B1_PSZ = 0;
    localparam int B2_RES_HI = 6;
    localparam int B2_EPE = 5;
    localparam int B2_RES_LO = 4;
    localparam int B2_SLE = 3;
    localparam int B2_PS2 = 2;
    localparam int B2_PS1 = 1;
    localparam int B2_ES = 0;

    // ==========================================================
    // Reset and fixed values
    localparam logic RESERVED_VAL = 1'b0;
    localparam logic SLE_RESET = 1'b1;
    localparam logic [2:0] BITCNT_LAST = 3'h7;
    localparam logic [2:0] BITCNT_ONE = 3'h1;
    localparam logic [2:0] BITCNT_ZERO = 3'h0;
    localparam logic [3:0] OUTIDX_ZERO = 4'h0;
    localparam logic [3:0] OUTIDX_TOP = 4'hf;
    // Arbitrary capacity code value
    localparam logic [3:0] DENSITY_DEFAULT = 4'h5;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int SLEEP_WAKE_DELAY_NS = 35000;
    localparam int ENTRY_CYCLES_DEF =
        (SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
        SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES_DEF =
        (SLEEP_WAKE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
        SLEEP_WAKE_DELAY_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    // ==========================================================
    // Power states
    typedef enum logic [1:0] {
        FSD_STANDBY,
        FSD_ENTER,
        FSD_SLEEP,
        FSD_WAKE
    } fsd_state_e;

endpackage

// [tb/fsd_host_model.sv]
// Serial host model that frames opcodes and collects returned bits
`timescale 1ns/100ps
module fsd_host_model (
    output logic cs_b,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe_b
);
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // ====================
    // One selected frame, clock still outside it
    task automatic xfer(input logic [7:0] op, input int nbits,
                        output logic [31:0] rx, output logic oe);
        rx = '0;
        oe = 1'b0;
        cs_b = 1'b0;
        #3;
        for (int i = 0; i < nbits; i++) begin
            si = op[7 - (i % 8)];
            #3 sck = 1'b1;
            if (i >= 8) begin
                rx = {rx[30:0], so};
            end
            oe = oe | !so_oe_b;
            #3 sck = 1'b0;
        end
        #3 cs_b = 1'b1;
        si = ~si;
        // Deselect long enough for the system clock to see frame end
        #30;
    endtask
endmodule // fsd_host_model

// [tb/fsd_status_sleep_assertions.sv]
// Port checker for the status and deep-sleep block
`timescale 1ns/100ps
module fsd_status_sleep_assertions #(
    parameter int ENTRY_CYCLES = 4,
    parameter int WAKE_CYCLES = 6,
    parameter logic [3:0] DENSITY_CODE = 4'h0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic so_oe_b,
    input wire logic op_busy,
    input wire logic compare_done,
    input wire logic compare_mismatch,
    input wire logic op_done,
    input wire logic op_error,
    input wire logic op_aborted,
    input wire logic protect_sw,
    input wire logic protect_pin_b,
    input wire logic page_size_528,
    input wire logic lockdown_disable,
    input wire logic suspend_buf1,
    input wire logic suspend_buf2,
    input wire logic erase_suspend,
    input wire logic [7:0] status_byte_first,
    input wire logic [7:0] status_byte_second,
    input wire logic standby_mode,
    input wire logic deep_sleep,
    input wire logic cmd_open,
    input wire logic lockdown_grant,
    input wire logic buf1_write_block,
    input wire logic buf2_write_block
);
    localparam int E_LO = ENTRY_CYCLES - 1;
    localparam int E_HI = ENTRY_CYCLES + 6;
    localparam int W_LO = WAKE_CYCLES - 1;
    localparam int W_HI = WAKE_CYCLES + 6;
    logic ldis_seen;

    // ====================
    // Lockdown disable memory
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ldis_seen <= 1'b0;
        end else if (lockdown_disable) begin
            ldis_seen <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_busy_ready: assert property (
        $stable(op_busy) [*3] |-> status_byte_second[7] == !op_busy)
        else $error("ready bit wrong");
    a_epe_set: assert property (
        op_done && op_error && !op_aborted |-> ##2 status_byte_second[5])
        else $error("error flag not set");
    a_epe_clear: assert property (
        op_done && (!op_error || op_aborted) |-> ##2 !status_byte_second[5])
        else $error("error flag set wrongly");
    a_cmp_flag: assert property (
        compare_done |-> ##2 status_byte_first[6] == $past(compare_mismatch, 2))
        else $error("compare flag wrong");
    a_lock_off: assert property (
        ldis_seen [*2] |-> !status_byte_second[3] && !lockdown_grant)
        else $error("lockdown still enabled");
    a_susp_flags: assert property (
        $stable({suspend_buf2, suspend_buf1, erase_suspend}) [*3] |->
        status_byte_second[2:0] == {suspend_buf2, suspend_buf1, erase_suspend})
        else $error("suspend flags wrong");
    a_buf_block: assert property (
        $stable({suspend_buf2, suspend_buf1}) [*2] |->
        {buf2_write_block, buf1_write_block} == {suspend_buf2, suspend_buf1})
        else $error("buffer block wrong");
    a_prot_page: assert property (
        $stable({protect_sw, protect_pin_b, page_size_528}) [*4] |->
        status_byte_first[1:0] == {protect_sw | !protect_pin_b, page_size_528})
        else $error("protect or page flag wrong");
    a_density: assert property (
        $past(rst_b) |-> status_byte_first[5:2] == DENSITY_CODE)
        else $error("capacity code wrong");
    a_sleep_quiet: assert property (
        deep_sleep |-> so_oe_b && !cmd_open && !standby_mode)
        else $error("active while asleep");
    a_entry_time: assert property (
        $fell(cmd_open) |-> ##[E_LO:E_HI] deep_sleep)
        else $error("sleep entry late");
    a_wake_time: assert property (
        $fell(deep_sleep) |-> ##[W_LO:W_HI] cmd_open && standby_mode)
        else $error("wake late");

    cover property (deep_sleep ##1 !deep_sleep);
    cover property (op_done && op_error && op_aborted);
    cover property ($rose(lockdown_grant));
endmodule // fsd_status_sleep_assertions

// [tb/test_fsd_status_sleep.sv]
// Self-checking bench for the status and deep-sleep block
`timescale 1ns/100ps
module test_fsd_status_sleep
    import fsd_pkg::*;
;
    localparam int ENTRY = 4;
    localparam int WAKE = 6;
    // Arbitrary capacity code
    localparam logic [3:0] DEN = 4'h9;
    logic clk, rst_b, sck, cs_b, si, so, so_oe_b, oe;
    logic op_busy, compare_done, compare_mismatch, op_done, op_error;
    logic op_aborted, protect_sw, protect_pin_b, page_size_528;
    logic lockdown_disable, lockdown_req, suspend_buf1, suspend_buf2;
    logic erase_suspend, standby_mode, deep_sleep, cmd_open;
    logic lockdown_grant, buf1_write_block, buf2_write_block;
    logic [7:0] status_byte_first, status_byte_second;
    logic m_cmp, m_epe, m_sle;
    logic [31:0] rx;
    int errors, checks;
    int cyc = 0;
    int short_len[2] = '{5, 12};

    fsd_status_sleep #(.ENTRY_CYCLES(ENTRY), .WAKE_CYCLES(WAKE),
        .DENSITY_CODE(DEN)) fsd_status_sleep_inst (
        .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
        .so(so), .so_oe_b(so_oe_b), .op_busy(op_busy),
        .compare_done(compare_done), .compare_mismatch(compare_mismatch),
        .op_done(op_done), .op_error(op_error), .op_aborted(op_aborted),
        .protect_sw(protect_sw), .protect_pin_b(protect_pin_b),
        .page_size_528(page_size_528), .lockdown_disable(lockdown_disable),
        .lockdown_req(lockdown_req), .suspend_buf1(suspend_buf1),
        .suspend_buf2(suspend_buf2), .erase_suspend(erase_suspend),
        .status_byte_first(status_byte_first),
        .status_byte_second(status_byte_second),
        .standby_mode(standby_mode), .deep_sleep(deep_sleep),
        .cmd_open(cmd_open), .lockdown_grant(lockdown_grant),
        .buf1_write_block(buf1_write_block),
        .buf2_write_block(buf2_write_block));

    fsd_host_model fsd_host_model_inst (.cs_b(cs_b), .sck(sck), .si(si),
        .so(so), .so_oe_b(so_oe_b));

    // ====================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic logic [15:0] exp_st();
        logic r;
        r = !op_busy;
        return {r, m_cmp, DEN, protect_sw | !protect_pin_b, page_size_528,
                r, 1'b0, m_epe, 1'b0, m_sle, suspend_buf2, suspend_buf1,
                erase_suspend};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic frame(input logic [7:0] op, input int n);
        fsd_host_model_inst.xfer(op, n, rx, oe);
    endtask

    task automatic st_check();
        tick(4);
        check({status_byte_first, status_byte_second}, exp_st());
        frame(OP_STATUS, 40);
        check(rx[31:16], exp_st());
        check(rx[15:0], exp_st());
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end

    // ====================
    // Main sequence
    initial begin
        void'($urandom(90));
        {errors, checks} = '0;
        {m_cmp, m_epe, m_sle, rst_b} = 4'h2;
        {op_busy, compare_done, compare_mismatch, op_done, op_error} = '0;
        {op_aborted, protect_sw, page_size_528, lockdown_disable} = '0;
        {lockdown_req, suspend_buf1, suspend_buf2, erase_suspend} = '0;
        protect_pin_b = 1'b1;
        tick(10);
        rst_b <= 1'b1;
        tick(3);
        st_check();
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            {op_busy, protect_sw, protect_pin_b, page_size_528} <= 4'($urandom);
            {suspend_buf1, suspend_buf2, erase_suspend} <= 3'($urandom);
            {compare_mismatch, op_error, op_aborted} <=
                (i < 2) ? {2'b11, i[0]} : 3'($urandom);
            {compare_done, op_done} <= 2'b11;
            @(posedge clk);
            {compare_done, op_done} <= 2'b00;
            m_cmp = compare_mismatch;
            m_epe = op_error & !op_aborted;
            st_check();
            check(16'({buf2_write_block, buf1_write_block}),
                  16'({suspend_buf2, suspend_buf1}));
        end
        @(posedge clk);
        {op_busy, lockdown_req} <= 2'b01;
        tick(3);
        check(16'(lockdown_grant), 16'h1);
        lockdown_disable <= 1'b1;
        tick(1);
        lockdown_disable <= 1'b0;
        m_sle = 1'b0;
        tick(3);
        check(16'(lockdown_grant), 16'h0);
        lockdown_req <= 1'b0;
        st_check();
        @(posedge clk);
        op_busy <= 1'b1;
        frame(OP_SLEEP, 8);
        tick(ENTRY + 20);
        check(16'({cmd_open, standby_mode}), 16'h2);
        op_busy <= 1'b0;
        foreach (short_len[k]) begin
            frame(OP_SLEEP, short_len[k]);
            tick(ENTRY + 20);
            check(16'(standby_mode), 16'h1);
        end
        frame(OP_SLEEP, 24);
        tick(ENTRY + 20);
        check(16'(deep_sleep), 16'h1);
        frame(OP_STATUS, 40);
        check(16'(oe), 16'h0);
        foreach (short_len[k]) begin
            frame(OP_WAKE, short_len[k]);
            tick(WAKE + 20);
            check(16'(deep_sleep), 16'h1);
        end
        frame(OP_WAKE, 16);
        tick(WAKE + 20);
        check(16'({standby_mode, deep_sleep}), 16'h2);
        st_check();
        frame(OP_SLEEP, 8);
        tick(ENTRY + 20);
        check(16'(deep_sleep), 16'h1);
        rst_b <= 1'b0;
        tick(3);
        check(16'({standby_mode, cmd_open, deep_sleep}), 16'h6);
        rst_b <= 1'b1;
        {m_cmp, m_epe, m_sle} = 3'h1;
        tick(3);
        st_check();
        print_verdict();
    end
endmodule // test_fsd_status_sleep

bind fsd_status_sleep fsd_status_sleep_assertions #(
    .ENTRY_CYCLES(ENTRY_CYCLES), .WAKE_CYCLES(WAKE_CYCLES),
    .DENSITY_CODE(DENSITY_CODE)) fsd_status_sleep_assertions_inst (
    .clk(clk), .rst_b(rst_b), .so_oe_b(so_oe_b), .op_busy(op_busy),
    .compare_done(compare_done), .compare_mismatch(compare_mismatch),
    .op_done(op_done), .op_error(op_error), .op_aborted(op_aborted),
    .protect_sw(protect_sw), .protect_pin_b(protect_pin_b),
    .page_size_528(page_size_528), .lockdown_disable(lockdown_disable),
    .suspend_buf1(suspend_buf1), .suspend_buf2(suspend_buf2),
    .erase_suspend(erase_suspend), .status_byte_first(status_byte_first),
    .status_byte_second(status_byte_second), .standby_mode(standby_mode),
    .deep_sleep(deep_sleep), .cmd_open(cmd_open),
    .lockdown_grant(lockdown_grant), .buf1_write_block(buf1_write_block),
    .buf2_write_block(buf2_write_block));
